// file: core/quasi_port_pkg.sv
// Shared constants and carrier types for the quasi-bidirectional port block
package quasi_port_pkg;

    // ==========================================================
    // Port geometry
    // ==========================================================
    localparam int EIGHT_PIN_WIDTH = 8;
    localparam int TWO_PIN_WIDTH = 2;
    localparam int PIN_COUNT = EIGHT_PIN_WIDTH + TWO_PIN_WIDTH;
    // Position of the two-pin port in the combined pin vector
    localparam int TWO_PIN_BASE = 8;

    // ==========================================================
    // Port selection codes on the access request
    // ==========================================================
    localparam logic SEL_EIGHT_PIN_PORT = 1'h0;
    localparam logic SEL_TWO_PIN_PORT = 1'h1;

    // ==========================================================
    // Values after reset
    // ==========================================================
    localparam logic [9:0] LATCH_RESET = 10'h3FF;
    localparam logic [9:0] SYNC_RESET = 10'h3FF;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // ==========================================================
    // Alternate-function bit positions
    // ==========================================================
    localparam int BIT_SER_RXD = 0;
    localparam int BIT_SER_TXD = 1;
    localparam int BIT_EXT_INT_ZERO = 2;
    localparam int BIT_EXT_INT_ONE = 3;
    localparam int BIT_CNT_IN_ZERO = 4;
    localparam int BIT_CNT_IN_ONE = 5;
    localparam int BIT_CAN_TX = 8;
    localparam int BIT_CAN_RX = 9;

    // ==========================================================
    // Transition boost timing
    // ==========================================================
    // Boost length in oscillator periods
    localparam logic [1:0] BOOST_OSC_PERIODS = 2'h2;
    // Default core clocks per oscillator period
    localparam int OSC_DIV_DEFAULT = 1;

    // ==========================================================
    // Carrier types
    // ==========================================================
    // One access from the core to a port
    typedef struct packed {
        logic write;       // Whole-byte load of the latches
        logic read;        // Read of the port onto the bus
        logic rmw;         // Read through the latch path
        logic bit_op;      // Single-bit read-modify-write
        logic port_sel;    // Which port is addressed
        logic [2:0] bit_idx;
        logic bit_val;
        logic [7:0] wdata;
    } port_req_s;

    // Pin levels handed to the peripherals, after synchronising
    typedef struct packed {
        logic ser_rxd;
        logic ext_interrupt_zero;
        logic ext_interrupt_one;
        logic counter_input_zero;
        logic counter_input_one;
        logic can_receive_pin;
    } periph_in_s;

endpackage : quasi_port_pkg

// file: core/quasi_bidir_port_latch.sv
// Latch-based quasi-bidirectional eight-pin and two-pin port logic
`timescale 1ns/1ps

module quasi_bidir_port_latch #(
    parameter int OSC_DIV = quasi_port_pkg::OSC_DIV_DEFAULT
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Core access side
    input wire quasi_port_pkg::port_req_s req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // Alternate-function outputs from peripherals
    input wire logic ser_txd_i,
    input wire logic can_tx_i,
    // Synchronised pin levels to peripherals
    output quasi_port_pkg::periph_in_s periph_o,
    // Pad side: all ten pins, two-pin port in the top bits
    input wire logic [9:0] pin_i,
    output logic [9:0] pin_o,
    output logic [9:0] pin_oe_o,
    output logic [9:0] boost_o
);

    // ==========================================================
    // Declarations
    // ==========================================================
    logic [9:0] latch_r;
    logic [9:0] latch_nxt;
    logic [9:0] sync1_r;
    logic [9:0] sync2_r;
    logic [9:0] alt_out;
    logic [7:0] latch_byte;
    logic [7:0] pin_byte;
    logic [7:0] rmw_byte;
    logic osc_tick;

    // ==========================================================
    // Oscillator-period divider
    // ==========================================================
    localparam int DIV_W = (OSC_DIV > 1) ? $clog2(OSC_DIV) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIV - 1);
    logic [DIV_W-1:0] div_r;

    // Free-running count, one tick per oscillator period
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_r <= '0;
        end else if (div_r == DIV_LAST) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + DIV_W'(1);
        end
    end

    assign osc_tick = (div_r == DIV_LAST);

    // ==========================================================
    // Views of the addressed port
    // ==========================================================
    // Narrow port reads its unused upper bits as zero
    always_comb begin
        if (req_i.port_sel == quasi_port_pkg::SEL_TWO_PIN_PORT) begin
            latch_byte = {6'h00, latch_r[9:8]};
            pin_byte = {6'h00, sync2_r[9:8]};
        end else begin
            latch_byte = latch_r[7:0];
            pin_byte = sync2_r[7:0];
        end
    end

    // Bit operation starts from the latch byte, never from the pins
    always_comb begin
        rmw_byte = latch_byte;
        rmw_byte[req_i.bit_idx] = req_i.bit_val;
    end

    // ==========================================================
    // Next latch value
    // ==========================================================
    // A bit index above 1 on the narrow port changes nothing there
    always_comb begin
        latch_nxt = latch_r;
        if (req_i.write) begin
            if (req_i.port_sel == quasi_port_pkg::SEL_TWO_PIN_PORT) begin
                latch_nxt[9:8] = req_i.wdata[1:0];
            end else begin
                latch_nxt[7:0] = req_i.wdata;
            end
        end else if (req_i.bit_op) begin
            if (req_i.port_sel == quasi_port_pkg::SEL_TWO_PIN_PORT) begin
                latch_nxt[9:8] = rmw_byte[1:0];
            end else begin
                latch_nxt[7:0] = rmw_byte;
            end
        end
    end

    // ==========================================================
    // Output latches
    // ==========================================================
    // All ones after reset: pins 1 and 8 follow ser_txd_i and can_tx_i, every other pin comes up as a pulled-up input
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            latch_r <= quasi_port_pkg::LATCH_RESET;
        end else begin
            latch_r <= latch_nxt;
        end
    end

    // ==========================================================
    // Pin synchroniser
    // ==========================================================
    // First stage feeds only the second; pads are asynchronous
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sync1_r <= quasi_port_pkg::SYNC_RESET;
            sync2_r <= quasi_port_pkg::SYNC_RESET;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    // One answer per read, one cycle later
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= quasi_port_pkg::RDATA_RESET;
            rvalid_o <= 1'b0;
        end else begin
            rvalid_o <= req_i.read;
            if (req_i.read) begin
                if (req_i.rmw) begin
                    rdata_o <= latch_byte;
                end else begin
                    rdata_o <= pin_byte;
                end
            end
        end
    end

    // ==========================================================
    // Alternate outputs
    // ==========================================================
    // Pins without an alternate output see a constant one here
    always_comb begin
        alt_out = '1;
        alt_out[quasi_port_pkg::BIT_SER_TXD] = ser_txd_i;
        alt_out[quasi_port_pkg::BIT_CAN_TX] = can_tx_i;
    end

    // ==========================================================
    // Pad drivers and transition boost, one slice per pin
    // ==========================================================
    genvar gi;
    generate
        for (gi = 0; gi < quasi_port_pkg::PIN_COUNT; gi++) begin : g_pin
            logic [1:0] boost_cnt_r;
            logic rise;

            assign rise = latch_nxt[gi] & ~latch_r[gi];

            // Only a low is ever driven; a high is left to the pull-ups
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    pin_o[gi] <= 1'b0;
                    pin_oe_o[gi] <= 1'b0;
                end else begin
                    pin_o[gi] <= 1'b0;
                    pin_oe_o[gi] <= ~(latch_r[gi] & alt_out[gi]);
                end
            end

            // Reset holds the boost off; only the weak pull-up acts
            always_ff @(posedge clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    boost_cnt_r <= 2'h0;
                    boost_o[gi] <= 1'b0;
                end else if (rise) begin
                    boost_cnt_r <= quasi_port_pkg::BOOST_OSC_PERIODS;
                    boost_o[gi] <= 1'b1;
                end else if (osc_tick && boost_cnt_r != 2'h0) begin
                    boost_cnt_r <= boost_cnt_r - 2'h1;
                    boost_o[gi] <= (boost_cnt_r != 2'h1);
                end
            end
        end
    endgenerate

    // ==========================================================
    // Peripheral inputs
    // ==========================================================
    // Taken from synchronised pins; latch must be one to see them
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            periph_o <= '1;
        end else begin
            periph_o.ser_rxd <= sync2_r[quasi_port_pkg::BIT_SER_RXD];
            periph_o.ext_interrupt_zero <=
                sync2_r[quasi_port_pkg::BIT_EXT_INT_ZERO];
            periph_o.ext_interrupt_one <=
                sync2_r[quasi_port_pkg::BIT_EXT_INT_ONE];
            periph_o.counter_input_zero <=
                sync2_r[quasi_port_pkg::BIT_CNT_IN_ZERO];
            periph_o.counter_input_one <=
                sync2_r[quasi_port_pkg::BIT_CNT_IN_ONE];
            periph_o.can_receive_pin <= sync2_r[quasi_port_pkg::BIT_CAN_RX];
        end
    end

endmodule : quasi_bidir_port_latch

// file: dv/quasi_pad_model.sv
// Pad-side model: pull-ups plus outside circuitry that may pull pins low
`timescale 1ns/1ps
module quasi_pad_model (
    // Design side
    input wire logic [9:0] oe_i,
    input wire logic [9:0] pin_i,
    // Test control
    input wire logic [9:0] pull_low_i,
    // Resolved pad levels
    output logic [9:0] pad_o
);
    // ==========================================================
    // Pad resolution
    // ==========================================================
    // A released pin rises on the pull-up unless something outside sinks it
    assign pad_o = (oe_i & pin_i) | (~oe_i & ~pull_low_i);
endmodule : quasi_pad_model

// file: dv/quasi_port_monitor.sv
// Assertion checker and its bind for the quasi-bidirectional port block
`timescale 1ns/1ps
module quasi_port_monitor #(
    parameter int OSC_DIV = 1
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Core side and alternate outputs
    input wire quasi_port_pkg::port_req_s req_i,
    input wire logic [7:0] rdata_o,
    input wire logic rvalid_o,
    input wire logic ser_txd_i,
    input wire logic can_tx_i,
    // Pads and peripherals
    input wire quasi_port_pkg::periph_in_s periph_o,
    input wire logic [9:0] pin_i,
    input wire logic [9:0] pin_o,
    input wire logic [9:0] pin_oe_o,
    input wire logic [9:0] boost_o
);
    // Pins feeding peripherals, in periph_o order
    logic [5:0] tap;
    assign tap = {pin_i[0], pin_i[2], pin_i[3], pin_i[4], pin_i[5], pin_i[9]};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    // ==========================================================
    // Access path
    // ==========================================================
    a_read_answer: assert property (req_i.read |=> rvalid_o)
        else $error("read not answered");
    a_rmw_readback: assert property (
        req_i.write && !req_i.port_sel ##1 req_i.read && req_i.rmw &&
        !req_i.port_sel && !req_i.write && !req_i.bit_op
        |=> rdata_o == $past(req_i.wdata, 2))
        else $error("latch read wrong");
    a_pin_read: assert property (
        req_i.read && !req_i.rmw && !req_i.port_sel
        |=> rdata_o == $past(pin_i[7:0], 3))
        else $error("pin read wrong");
    a_periph_sync: assert property (periph_o == $past(tap, 3))
        else $error("peripheral input wrong");
    // ==========================================================
    // Pin drive
    // ==========================================================
    a_write_drive: assert property (
        req_i.write && !req_i.port_sel
        |=> ##1 pin_oe_o[7:2] == ~$past(req_i.wdata[7:2], 2))
        else $error("drive does not follow latch");
    a_txd_alt: assert property (
        req_i.write && !req_i.port_sel && req_i.wdata[1]
        |=> ##1 pin_oe_o[1] == !$past(ser_txd_i))
        else $error("serial output not on pin");
    a_can_alt: assert property (
        req_i.write && req_i.port_sel && req_i.wdata[0]
        |=> ##1 pin_oe_o[8] == !$past(can_tx_i))
        else $error("bus transmit not on pin");
    // ==========================================================
    // Transition boost; lengths assume OSC_DIV of one
    // ==========================================================
    // Boost starts with the latch, one cycle ahead of the pin release
    a_boost_two: assert property (
        $fell(pin_oe_o[7]) |-> $past(boost_o[7]) && boost_o[7] ##1
        !boost_o[7])
        else $error("boost length wrong");
    a_boost_cause: assert property (
        $rose(boost_o[7]) |=> $fell(pin_oe_o[7]))
        else $error("boost without rise");
    a_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
        !resetn_i |-> boost_o == '0 && pin_oe_o == '0 && pin_o == '0)
        else $error("drive during reset");
    c_read: cover property (req_i.read ##1 rvalid_o);
    c_boost: cover property ($rose(boost_o[7]));
    c_rx_low: cover property ($fell(periph_o.can_receive_pin));
endmodule : quasi_port_monitor

bind quasi_bidir_port_latch quasi_port_monitor #(.OSC_DIV(OSC_DIV)) mon (
    .clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
    .rvalid_o(rvalid_o), .ser_txd_i(ser_txd_i), .can_tx_i(can_tx_i),
    .periph_o(periph_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .boost_o(boost_o));

// file: dv/quasi_bidir_port_latch_test.sv
// Self-checking bench for the quasi-bidirectional port block
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
    $display("ERROR %0t: got %h want %h", $time, a, b); end end
module quasi_bidir_port_latch_test;
    typedef struct packed {
        logic sel;
        logic [7:0] wd;
        logic [9:0] ext;
        logic [7:0] el;
        logic [7:0] ep;
    } row_s;
    // Opcodes: {write, read, rmw, bit_op}
    localparam logic [3:0] WR = 4'h8;
    localparam logic [3:0] RL = 4'h6;
    localparam logic [3:0] RP = 4'h4;
    localparam logic [3:0] BO = 4'h1;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b1;
    quasi_port_pkg::port_req_s req_i = '0;
    logic [7:0] rdata_o;
    logic rvalid_o;
    logic ser_txd_i = 1'b1;
    logic can_tx_i = 1'b1;
    quasi_port_pkg::periph_in_s periph_o;
    logic [9:0] pin_w;
    logic [9:0] pin_o;
    logic [9:0] pin_oe_o;
    logic [9:0] boost_o;
    logic [9:0] ext = 10'h000;
    int errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    // Columns: port, written byte, outside lows, latch read, pin read
    row_s rows [6] = '{'{1'h0, 8'hA5, 10'h000, 8'hA5, 8'hA5},
                       '{1'h0, 8'hFF, 10'h00F, 8'hFF, 8'hF0},
                       '{1'h0, 8'h3C, 10'h081, 8'h3C, 8'h3C},
                       '{1'h1, 8'h02, 10'h000, 8'h02, 8'h02},
                       '{1'h1, 8'hFD, 10'h200, 8'h01, 8'h01},
                       '{1'h1, 8'hFF, 10'h100, 8'h03, 8'h02}};

    quasi_bidir_port_latch #(.OSC_DIV(1)) uut (.clk_i(clk_i),
        .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o),
        .rvalid_o(rvalid_o), .ser_txd_i(ser_txd_i), .can_tx_i(can_tx_i),
        .periph_o(periph_o), .pin_i(pin_w), .pin_o(pin_o),
        .pin_oe_o(pin_oe_o), .boost_o(boost_o));
    quasi_pad_model pads (.oe_i(pin_oe_o), .pin_i(pin_o),
        .pull_low_i(ext), .pad_o(pin_w));

    // ==========================================================
    // Clock, hang guard and verdict
    // ==========================================================
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // One request for one cycle, then an idle cycle
    task automatic access(input quasi_port_pkg::port_req_s r);
        @(negedge clk_i);
        req_i = r;
        @(negedge clk_i);
        req_i = '0;
    endtask : access
    // Answer stands for one cycle only, so it is looked at right away
    task automatic rd(input logic s, input logic [3:0] op, input logic [7:0] e);
        @(negedge clk_i);
        req_i = {op, s, 4'h0, 8'h00};
        @(negedge clk_i);
        req_i = '0;
        `CHK(rvalid_o, 1'b1)
        `CHK(rdata_o, e)
    endtask : rd
    task automatic settle();
        repeat (4) @(negedge clk_i);
    endtask : settle

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        // Reset edge lands before the first clock edge, so no unknowns
        #1 resetn_i = 1'b0;
        repeat (4) @(negedge clk_i);
        resetn_i = 1'b1;
        `CHK(pin_oe_o, 10'h000)
        `CHK(pin_o, 10'h000)
        `CHK(periph_o, 6'h3F)
        rd(1'h0, RL, 8'hFF);
        rd(1'h1, RL, 8'h03);
        foreach (rows[i]) begin
            ext = rows[i].ext;
            access({WR, rows[i].sel, 4'h0, rows[i].wd});
            settle();
            rd(rows[i].sel, RL, rows[i].el);
            rd(rows[i].sel, RP, rows[i].ep);
        end
        // Zero-to-one on bit 7 alone must boost that pin only
        ext = 10'h000;
        access({WR, 1'h0, 4'h0, 8'h00});
        settle();
        `CHK(pin_oe_o[7:0], 8'hFF)
        `CHK(pin_o, 10'h000)
        // Boost rises with the latch edge, two cycles before it drops
        access({WR, 1'h0, 4'h0, 8'h80});
        `CHK(boost_o, 10'h080)
        @(negedge clk_i);
        `CHK(boost_o, 10'h080)
        `CHK(pin_oe_o[7], 1'b0)
        @(negedge clk_i);
        `CHK(boost_o, 10'h000)
        @(negedge clk_i);
        `CHK(boost_o, 10'h000)
        // Bit operations rewrite the byte; bad index and write priority
        access({BO, 1'h0, 4'h7, 8'h00});
        rd(1'h0, RL, 8'h88);
        access({BO, 1'h0, 4'hE, 8'h00});
        rd(1'h0, RL, 8'h08);
        access({BO, 1'h1, 4'hA, 8'h00});
        rd(1'h1, RL, 8'h03);
        access({WR | BO, 1'h0, 4'h1, 8'h40});
        rd(1'h0, RL, 8'h40);
        // Write then latch read in back-to-back cycles
        @(negedge clk_i);
        req_i = {WR, 1'h0, 4'h0, 8'h5A};
        @(negedge clk_i);
        req_i = {RL, 1'h0, 4'h0, 8'h00};
        @(negedge clk_i);
        req_i = '0;
        `CHK(rdata_o, 8'h5A)
        // Serial and bus transmit outputs steer their pins
        access({WR, 1'h0, 4'h0, 8'h42});
        settle();
        rd(1'h0, RP, 8'h42);
        ser_txd_i = 1'b0;
        settle();
        rd(1'h0, RP, 8'h40);
        ser_txd_i = 1'b1;
        can_tx_i = 1'b0;
        settle();
        rd(1'h1, RP, 8'h02);
        can_tx_i = 1'b1;
        // Peripheral inputs follow the synchronised pins
        access({WR, 1'h0, 4'h0, 8'hFF});
        ext = 10'h23D;
        settle();
        `CHK(periph_o, 6'h00)
        ext = 10'h0C4;
        settle();
        `CHK(periph_o, 6'h2F)
        // Reset in mid-run restores ones without a boost
        ext = 10'h000;
        access({WR, 1'h0, 4'h0, 8'h00});
        settle();
        resetn_i = 1'b0;
        settle();
        `CHK(boost_o, 10'h000)
        resetn_i = 1'b1;
        rd(1'h0, RL, 8'hFF);
        `CHK(boost_o, 10'h000)
        report_and_stop();
    end
endmodule : quasi_bidir_port_latch_test
